// ===== dv/pks_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module pks_host_model (
  input  wire logic mclk,
  output logic      hold_power_bit,
  output logic      stay_awake_refresh,
  output logic      vbsw_sw_disable,
  output logic      vbsw_cmd_on,
  output logic      vbsw_flag_read
);
  initial begin
    {hold_power_bit, vbsw_sw_disable} = 2'h0;
    {stay_awake_refresh, vbsw_flag_read, vbsw_cmd_on} = 3'h0;
  end

  // Strobes last exactly one cycle, as a real SPI frame decode would
  task automatic pulse(input int sel);
    @(posedge mclk);
    #1;
    case (sel)
      0: stay_awake_refresh = 1'b1;
      1: vbsw_flag_read = 1'b1;
      default: vbsw_cmd_on = 1'b1;
    endcase
    @(posedge mclk);
    #1;
    {stay_awake_refresh, vbsw_flag_read, vbsw_cmd_on} = 3'h0;
  endtask

  task automatic set_level(input int sel, input logic v);
    @(posedge mclk);
    #1;
    if (sel == 0)
      hold_power_bit = v;
    else
      vbsw_sw_disable = v;
  endtask
endmodule

`default_nettype wire

// ===== dv/power_keepalive_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module power_keepalive_sequencer_tb;
  import pks_pkg::*;
  localparam int RST_CYC = 50;
  localparam int KA_CYC  = 40;
  logic mclk, rst_n, wake_in, ignition_input, io_level_select;
  logic prereg_above_uv, io_rail_uv_raw, io_rail_ov_raw;
  logic vbsw_overcurrent_raw, rails_in_range, first_watchdog_ok;
  wire logic hold_power_bit, stay_awake_refresh, vbsw_sw_disable;
  wire logic vbsw_cmd_on, vbsw_flag_read;
  logic io_five_volt_sel, io_rail_uv_fault, io_rail_ov_fault;
  logic switched_battery_out, vbsw_oc_flag, fixed_five_volt_rail_en;
  logic io_rail_en, core_rail_en, reset_out, keep_alive_active;
  pks_state_t  seq_state;
  logic [11:0] obs;
  int          bad_count;
  int          samples_checked;
  int          cyc;
  int          n;

  assign obs = {seq_state === ST_PWRUP, seq_state === ST_PWRDN,
                keep_alive_active, reset_out, core_rail_en, io_rail_en,
                fixed_five_volt_rail_en, vbsw_oc_flag, switched_battery_out,
                io_rail_ov_fault, io_rail_uv_fault, io_five_volt_sel};

  pks_top #(.RST_HOLD_CYC(RST_CYC), .KA_CYC(KA_CYC)) DUT (
    .mclk(mclk), .rst_n(rst_n), .wake_in(wake_in),
    .ignition_input(ignition_input), .io_level_select(io_level_select),
    .prereg_above_uv(prereg_above_uv), .io_rail_uv_raw(io_rail_uv_raw),
    .io_rail_ov_raw(io_rail_ov_raw),
    .vbsw_overcurrent_raw(vbsw_overcurrent_raw),
    .rails_in_range(rails_in_range), .first_watchdog_ok(first_watchdog_ok),
    .hold_power_bit(hold_power_bit), .stay_awake_refresh(stay_awake_refresh),
    .vbsw_sw_disable(vbsw_sw_disable), .vbsw_cmd_on(vbsw_cmd_on),
    .vbsw_flag_read(vbsw_flag_read), .io_five_volt_sel(io_five_volt_sel),
    .io_rail_uv_fault(io_rail_uv_fault), .io_rail_ov_fault(io_rail_ov_fault),
    .switched_battery_out(switched_battery_out), .vbsw_oc_flag(vbsw_oc_flag),
    .fixed_five_volt_rail_en(fixed_five_volt_rail_en),
    .io_rail_en(io_rail_en), .core_rail_en(core_rail_en),
    .reset_out(reset_out), .keep_alive_active(keep_alive_active),
    .seq_state(seq_state));

  pks_host_model u_host (
    .mclk(mclk), .hold_power_bit(hold_power_bit),
    .stay_awake_refresh(stay_awake_refresh),
    .vbsw_sw_disable(vbsw_sw_disable), .vbsw_cmd_on(vbsw_cmd_on),
    .vbsw_flag_read(vbsw_flag_read));

  always #50 mclk = ~mclk;

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Ceiling well above the roughly 6000 cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic chk_bit(input string nm, input int i, input logic e);
    samples_checked++;
    if (obs[i] !== e) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", nm, e, obs[i]);
    end
  endtask

  task automatic chk_st(input string nm, input pks_state_t e);
    samples_checked++;
    if (seq_state !== e) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, seq_state);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi,
                         input int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  // Counts edges until the bit matches, bounded by lim
  task automatic wait_bit(input int i, input logic v, input int lim,
                          output int k);
    k = 0;
    while (obs[i] !== v && k < lim) begin
      step(1);
      k++;
    end
  endtask

  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    {wake_in, ignition_input, io_level_select, prereg_above_uv} = 4'h0;
    {io_rail_uv_raw, io_rail_ov_raw, vbsw_overcurrent_raw} = 3'h0;
    {rails_in_range, first_watchdog_ok} = 2'h1;
    step(4);
    rst_n = 1'b1;
    chk_st("state_after_reset", ST_OFF);
    io_level_select = 1'b1;
    step(1);
    prereg_above_uv = 1'b1;
    wait_bit(0, 1'b1, 10, n);
    chk_bit("level_latched", 0, 1'b1);
    io_level_select = 1'b0;
    step(10);
    chk_bit("level_kept", 0, 1'b1);
    $display("test level_latch done");

    wake_in = 1'b1;
    wait_bit(11, 1'b1, 10, n);
    chk_bit("core_on_at_wake", 7, 1'b1);
    wait_bit(6, 1'b1, 2100, n);
    chk_rng("rail_delay", 1998, 2002, n);
    chk_bit("five_on", 5, 1'b1);
    chk_st("on_state", ST_ON);
    chk_bit("vbsw_on", 3, 1'b1);
    chk_bit("reset_held", 8, 1'b0);
    rails_in_range = 1'b1;
    wait_bit(8, 1'b1, 80, n);
    chk_rng("reset_delay", RST_CYC + 2, RST_CYC + 6, n);
    $display("test power_up done");

    for (int i = 1; i <= 2; i++) begin
      {io_rail_ov_raw, io_rail_uv_raw} = 2'(i);
      step(100);
      {io_rail_ov_raw, io_rail_uv_raw} = 2'h0;
      step(10);
      chk_bit("short_glitch", i, 1'b0);
      {io_rail_ov_raw, io_rail_uv_raw} = 2'(i);
      wait_bit(i, 1'b1, 200, n);
      chk_rng("filter_delay", 122, 127, n);
      {io_rail_ov_raw, io_rail_uv_raw} = 2'h0;
      wait_bit(i, 1'b0, 10, n);
      chk_bit("fault_gone", i, 1'b0);
    end
    $display("test rail_filter done");

    u_host.set_level(1, 1'b1);
    step(3);
    chk_bit("vbsw_disabled", 3, 1'b0);
    u_host.set_level(1, 1'b0);
    first_watchdog_ok = 1'b0;
    step(8);
    chk_bit("vbsw_wd_off", 3, 1'b0);
    first_watchdog_ok = 1'b1;
    wait_bit(3, 1'b1, 8, n);
    chk_bit("vbsw_back", 3, 1'b1);
    vbsw_overcurrent_raw = 1'b1;
    wait_bit(4, 1'b1, 1000, n);
    chk_rng("trip_delay", 901, 906, n);
    chk_bit("vbsw_tripped", 3, 1'b0);
    vbsw_overcurrent_raw = 1'b0;
    step(6);
    u_host.pulse(2);
    step(2);
    chk_bit("cmd_refused", 3, 1'b0);
    u_host.pulse(1);
    chk_bit("flag_cleared", 4, 1'b0);
    step(3);
    chk_bit("still_off", 3, 1'b0);
    u_host.pulse(2);
    wait_bit(3, 1'b1, 3, n);
    chk_bit("vbsw_reenabled", 3, 1'b1);
    $display("test battery_switch done");

    ignition_input = 1'b1;
    step(5);
    wake_in = 1'b0;
    wait_bit(9, 1'b1, 8, n);
    chk_bit("ka_entered", 9, 1'b1);
    wait_bit(9, 1'b0, KA_CYC + 10, n);
    chk_rng("ka_window", KA_CYC - 2, KA_CYC + 2, n);
    chk_st("ignition_keeps_on", ST_ON);
    ignition_input = 1'b0;
    wake_in = 1'b1;
    step(6);
    wake_in = 1'b0;
    wait_bit(9, 1'b1, 8, n);
    u_host.set_level(0, 1'b1);
    wait_bit(9, 1'b0, 3, n);
    chk_st("hold_keeps_on", ST_ON);
    u_host.set_level(0, 1'b0);
    wake_in = 1'b1;
    step(6);
    wake_in = 1'b0;
    wait_bit(9, 1'b1, 8, n);
    repeat (3) begin
      step(KA_CYC - 15);
      u_host.pulse(0);
    end
    chk_bit("ka_refreshed", 9, 1'b1);
    wait_bit(10, 1'b1, KA_CYC + 5, n);
    chk_rng("ka_expiry", KA_CYC - 3, KA_CYC + 1, n);
    wait_bit(7, 1'b0, 2100, n);
    chk_rng("core_off_delay", 1998, 2002, n);
    chk_st("off_again", ST_OFF);
    step(1);
    chk_bit("vbsw_standby", 3, 1'b0);
    $display("test keep_alive done");

    rst_n = 1'b0;
    step(2);
    chk_bit("sel_cleared_by_reset", 0, 1'b0);
    rst_n = 1'b1;
    step(10);
    chk_st("state_after_second_reset", ST_OFF);
    io_level_select = 1'b1;
    step(10);
    chk_bit("level_low_relatched", 0, 1'b0);
    $display("test second_reset done");
    close_out();
  end
endmodule

`default_nettype wire

// ===== hw/pks_defines.svh
// How it works
// - Level select is caught once, at the first pre-regulator good, kept till reset.
// - Latched level low picks the 3.3 V I/O rail, high picks 5 V.
// - I/O rail under/overvoltage reported only after persisting 12 us.
// - Battery switch on outside standby while the first watchdog is served.
// - Software control turns the battery switch off at any time.
// - Overcurrent lasting the shutdown delay trips the switch and sets its flag.
// - After a trip, stay off until fault gone, flag read-cleared, command written.
// - Wake-up input leaves the off state and starts power-up.
// - Stay on while ignition high, hold-power set, or stay-awake refreshed.
// - Each wake-up falling edge in the on state enters keep-alive and starts a window.
// - Hold-power set during the window keeps the device powered.
// - Each stay-awake refresh in keep-alive restarts a full window.
// - Window expiring with no stay-on condition starts power-down.
// - Five volt and I/O rails start 200 us after pre-regulator good.
// - Core rail switches off 200 us after the window ends.
// - Reset held low until rails in range, then released after 12 ms.
`ifndef PKS_DEFINES_SVH
`define PKS_DEFINES_SVH

`define PKS_CLK_MHZ      10
`define PKS_T_FLT_US     12
`define PKS_T_OC_MIN_US  90
`define PKS_T_SEQ_US     200
`define PKS_T_RST_US     12000
`define PKS_T_KA_US      100000
`define PKS_FLT_CYC      (`PKS_T_FLT_US * `PKS_CLK_MHZ)
`define PKS_OC_CYC       (`PKS_T_OC_MIN_US * `PKS_CLK_MHZ)
`define PKS_SEQ_CYC      (`PKS_T_SEQ_US * `PKS_CLK_MHZ)
`define PKS_RST_CYC      (`PKS_T_RST_US * `PKS_CLK_MHZ)
`define PKS_KA_CYC       (`PKS_T_KA_US * `PKS_CLK_MHZ)

`define PKS_NPIN         9
`define PKS_PIN_WAKE     0
`define PKS_PIN_IGN      1
`define PKS_PIN_LVL      2
`define PKS_PIN_PREREG   3
`define PKS_PIN_UV       4
`define PKS_PIN_OV       5
`define PKS_PIN_OC       6
`define PKS_PIN_RANGE    7
`define PKS_PIN_WD       8
`define PKS_LONG_W       24

`endif

// ===== hw/pks_pkg.sv
`include "pks_defines.svh"
`default_nettype none

package pks_pkg;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_PWRUP,
    ST_ON,
    ST_KA,
    ST_PWRDN
  } pks_state_t;

  typedef struct packed {
    pks_state_t                  st;
    logic [`PKS_NPIN-1:0]        sy1;
    logic [`PKS_NPIN-1:0]        sy2;
    logic [`PKS_NPIN-1:0]        sy3;
    logic [`PKS_NPIN-1:0]        flt;
    logic                        wake_prev;
    logic                        lvl_done;
    logic                        lvl_val;
    logic [7:0]                  uv_cnt;
    logic [7:0]                  ov_cnt;
    logic                        uv_f;
    logic                        ov_f;
    logic [9:0]                  oc_cnt;
    logic                        tripped;
    logic                        oc_flag;
    logic                        vbsw;
    logic [11:0]                 seq_cnt;
    logic [`PKS_LONG_W-1:0]      ka_cnt;
    logic [`PKS_LONG_W-1:0]      rst_cnt;
    logic                        rail5_en;
    logic                        io_en;
    logic                        core_en;
    logic                        rst_out;
    logic                        ka_act;
  } pks_regs_t;

endpackage
`default_nettype wire

// ===== hw/pks_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pks_defines.svh"

module pks_top #(
  parameter int unsigned RST_HOLD_CYC = `PKS_RST_CYC,
  parameter int unsigned KA_CYC       = `PKS_KA_CYC
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic wake_in,
  input  wire logic ignition_input,
  input  wire logic io_level_select,
  input  wire logic prereg_above_uv,
  input  wire logic io_rail_uv_raw,
  input  wire logic io_rail_ov_raw,
  input  wire logic vbsw_overcurrent_raw,
  input  wire logic rails_in_range,
  input  wire logic first_watchdog_ok,
  input  wire logic hold_power_bit,
  input  wire logic stay_awake_refresh,
  input  wire logic vbsw_sw_disable,
  input  wire logic vbsw_cmd_on,
  input  wire logic vbsw_flag_read,
  output logic      io_five_volt_sel,
  output logic      io_rail_uv_fault,
  output logic      io_rail_ov_fault,
  output logic      switched_battery_out,
  output logic      vbsw_oc_flag,
  output logic      fixed_five_volt_rail_en,
  output logic      io_rail_en,
  output logic      core_rail_en,
  output logic      reset_out,
  output logic      keep_alive_active,
  output pks_pkg::pks_state_t seq_state
);
  import pks_pkg::*;

  localparam logic [7:0]  FLT_END = 8'(`PKS_FLT_CYC - 1);
  localparam logic [9:0]  OC_END  = 10'(`PKS_OC_CYC - 1);
  localparam logic [11:0] SEQ_END = 12'(`PKS_SEQ_CYC - 1);
  localparam logic [`PKS_LONG_W-1:0] RST_END =
    `PKS_LONG_W'(RST_HOLD_CYC - 1);
  localparam logic [`PKS_LONG_W-1:0] KA_END =
    `PKS_LONG_W'(KA_CYC - 1);

  pks_regs_t r_reg;
  pks_regs_t r_next;

  function automatic logic [7:0] flt_step(input logic [7:0] c,
                                          input logic       act);
    if (!act) begin
      return 8'h00;
    end
    return (c == FLT_END) ? c : c + 8'h01;
  endfunction

  logic [`PKS_NPIN-1:0] pins;
  assign pins = {first_watchdog_ok, rails_in_range, vbsw_overcurrent_raw,
                 io_rail_ov_raw, io_rail_uv_raw, prereg_above_uv,
                 io_level_select, ignition_input, wake_in};

  logic wake_f;
  logic ign_f;
  logic pre_f;
  logic oc_f;
  logic stay_on;
  logic ka_end;
  assign wake_f  = r_reg.flt[`PKS_PIN_WAKE];
  assign ign_f   = r_reg.flt[`PKS_PIN_IGN];
  assign pre_f   = r_reg.flt[`PKS_PIN_PREREG];
  assign oc_f    = r_reg.flt[`PKS_PIN_OC];
  assign stay_on = ign_f | hold_power_bit;
  assign ka_end  = (r_reg.ka_cnt == KA_END);

  always_comb begin
    r_next = r_reg;
    // Filter flop only moves the clean value once stages two and three agree
    r_next.sy1 = pins;
    r_next.sy2 = r_reg.sy1;
    r_next.sy3 = r_reg.sy2;
    r_next.flt = (r_reg.sy2 & r_reg.sy3) |
                 (r_reg.flt & (r_reg.sy2 | r_reg.sy3));
    r_next.wake_prev = wake_f;

    if (!r_reg.lvl_done && pre_f) begin
      r_next.lvl_done = 1'b1;
      r_next.lvl_val  = r_reg.flt[`PKS_PIN_LVL];
    end

    r_next.uv_cnt = flt_step(r_reg.uv_cnt, r_reg.flt[`PKS_PIN_UV]);
    r_next.ov_cnt = flt_step(r_reg.ov_cnt, r_reg.flt[`PKS_PIN_OV]);
    r_next.uv_f = r_reg.flt[`PKS_PIN_UV] && r_reg.uv_cnt == FLT_END;
    r_next.ov_f = r_reg.flt[`PKS_PIN_OV] && r_reg.ov_cnt == FLT_END;

    // Overcurrent count only runs while the switch actually drives
    if (oc_f && r_reg.vbsw) begin
      r_next.oc_cnt = (r_reg.oc_cnt == OC_END) ? 10'h000
                                               : r_reg.oc_cnt + 10'h001;
    end else begin
      r_next.oc_cnt = 10'h000;
    end
    if (vbsw_flag_read) begin
      r_next.oc_flag = 1'b0;
    end
    if (vbsw_cmd_on && !r_reg.oc_flag && !oc_f) begin
      r_next.tripped = 1'b0;
    end
    // Trip is set last so it wins over a same-cycle read or command
    if (oc_f && r_reg.vbsw && r_reg.oc_cnt == OC_END) begin
      r_next.tripped = 1'b1;
      r_next.oc_flag = 1'b1;
    end
    r_next.vbsw = (r_reg.st != ST_OFF) && r_reg.flt[`PKS_PIN_WD] &&
                  !vbsw_sw_disable && !r_next.tripped;

    unique case (r_reg.st)
      ST_OFF: begin
        r_next.seq_cnt = 12'h000;
        if (wake_f) begin
          r_next.st      = ST_PWRUP;
          r_next.core_en = 1'b1;
        end
      end
      ST_PWRUP: begin
        if (!pre_f) begin
          r_next.seq_cnt = 12'h000;
        end else if (r_reg.seq_cnt == SEQ_END) begin
          r_next.rail5_en = 1'b1;
          r_next.io_en    = 1'b1;
          r_next.st       = ST_ON;
        end else begin
          r_next.seq_cnt = r_reg.seq_cnt + 12'h001;
        end
      end
      ST_ON: begin
        if (r_reg.wake_prev && !wake_f) begin
          r_next.st     = ST_KA;
          r_next.ka_cnt = '0;
        end
      end
      ST_KA: begin
        if (wake_f || hold_power_bit) begin
          r_next.st = ST_ON;
        end else if (stay_awake_refresh) begin
          r_next.ka_cnt = '0;
        end else if (ka_end) begin
          if (stay_on) begin
            r_next.st = ST_ON;
          end else begin
            r_next.st      = ST_PWRDN;
            r_next.seq_cnt = 12'h000;
          end
        end else begin
          r_next.ka_cnt = r_reg.ka_cnt + `PKS_LONG_W'(1);
        end
      end
      ST_PWRDN: begin
        if (r_reg.seq_cnt == SEQ_END) begin
          r_next.core_en  = 1'b0;
          r_next.rail5_en = 1'b0;
          r_next.io_en    = 1'b0;
          r_next.st       = ST_OFF;
        end else begin
          r_next.seq_cnt = r_reg.seq_cnt + 12'h001;
        end
      end
      // Three unused codes of the state field fall back to standby
      default: begin
        r_next.st = ST_OFF;
      end
    endcase
    // Keep-alive flag kept as its own flop so the pin is glitch free
    r_next.ka_act = (r_next.st == ST_KA);

    // Any loss of range restarts the full hold time
    if (!r_reg.flt[`PKS_PIN_RANGE] || !r_reg.io_en) begin
      r_next.rst_cnt = '0;
      r_next.rst_out = 1'b0;
    end else if (r_reg.rst_cnt == RST_END) begin
      r_next.rst_out = 1'b1;
    end else begin
      r_next.rst_cnt = r_reg.rst_cnt + `PKS_LONG_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign io_five_volt_sel        = r_reg.lvl_val;
  assign io_rail_uv_fault        = r_reg.uv_f;
  assign io_rail_ov_fault        = r_reg.ov_f;
  assign switched_battery_out    = r_reg.vbsw;
  assign vbsw_oc_flag            = r_reg.oc_flag;
  assign fixed_five_volt_rail_en = r_reg.rail5_en;
  assign io_rail_en              = r_reg.io_en;
  assign core_rail_en            = r_reg.core_en;
  assign reset_out               = r_reg.rst_out;
  assign keep_alive_active       = r_reg.ka_act;
  assign seq_state               = r_reg.st;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_LVL_HELD: assert property (
    r_reg.lvl_done |=> r_reg.lvl_done && $stable(r_reg.lvl_val))
    else $error("level select changed after latch");

  AST_LVL_SAMPLE: assert property (
    $rose(r_reg.lvl_done) |-> io_five_volt_sel == $past(r_reg.flt[2])
                              && $past(pre_f))
    else $error("level select sampled wrongly");

  AST_UV_FILTER: assert property (
    $rose(r_reg.uv_f) |-> $past(r_reg.uv_cnt) == FLT_END
                          && $past(r_reg.flt[4], 2))
    else $error("undervoltage reported before filter time");

  AST_VBSW_STANDBY: assert property (
    r_reg.st == ST_OFF |=> !switched_battery_out)
    else $error("battery switch on in standby");

  AST_VBSW_DISABLE: assert property (
    vbsw_sw_disable |=> !switched_battery_out)
    else $error("battery switch ignored software off");

  AST_OC_TRIP: assert property (
    oc_f && r_reg.vbsw && r_reg.oc_cnt == OC_END
    |=> r_reg.tripped && vbsw_oc_flag && !switched_battery_out)
    else $error("overcurrent did not trip");

  AST_TRIP_HOLD: assert property (
    r_reg.tripped && !vbsw_cmd_on |=> r_reg.tripped ##0 !switched_battery_out)
    else $error("battery switch left trip without command");

  AST_WAKE_UP: assert property (
    r_reg.st == ST_OFF && wake_f |=> r_reg.st == ST_PWRUP && core_rail_en)
    else $error("wake-up did not start power-up");

  AST_KA_ENTRY: assert property (
    r_reg.st == ST_ON && r_reg.wake_prev && !wake_f
    |=> keep_alive_active && r_reg.ka_cnt == '0)
    else $error("wake-up fall did not open window");

  AST_KA_REFRESH: assert property (
    r_reg.st == ST_KA && !wake_f && !hold_power_bit && stay_awake_refresh
    |=> r_reg.ka_cnt == '0)
    else $error("refresh did not restart window");

  AST_KA_EXPIRE: assert property (
    r_reg.st == ST_KA && ka_end && !stay_on && !wake_f
    && !stay_awake_refresh |=> r_reg.st == ST_PWRDN)
    else $error("window expiry did not power down");

  AST_RAILS_UP: assert property (
    $rose(io_rail_en) |-> $past(r_reg.seq_cnt) == SEQ_END
                          && fixed_five_volt_rail_en)
    else $error("rails started at wrong time");

  AST_CORE_OFF: assert property (
    $fell(core_rail_en) |-> $past(r_reg.st) == ST_PWRDN
                            && $past(r_reg.seq_cnt) == SEQ_END)
    else $error("core rail off at wrong time");

  AST_RST_HOLD: assert property (
    $rose(reset_out) |-> $past(r_reg.rst_cnt) == RST_END
                         && $past(r_reg.flt[7]))
    else $error("reset released early");

  COV_POWER_UP: cover property (r_reg.st == ST_PWRUP ##1 r_reg.st == ST_ON);
  COV_KA_DOWN: cover property (r_reg.st == ST_KA ##1 r_reg.st == ST_PWRDN);
  COV_TRIP: cover property ($rose(r_reg.tripped));
  COV_RESET_UP: cover property ($rose(reset_out));

endmodule
`default_nettype wire
